// file: mcr_pkg.sv
// How it works
// - read-only 24-bit unsigned line-cycle apparent energy result is readable.
// - 16-bit operating control register, resets to 0x000c, always readable.
// - mask bits gate the interrupt pin; flags still latch; mask resets 0x40.
// - 16-bit read-only interrupt flag register, resets to zero.
// - clear-on-read alias returns the flags, then clears them all.
// - current offset bits 0..5 are sign-magnitude offset; bit 6 unused.
// - current offset top bit switches the integrator on; resets off.
// - voltage offset applied with inverted polarity; bits 6 and 7 unused.
// - 8-bit amplifier gain select for both channels, resets to zero.
// - 6-bit phase calibration resets 0x0d; host writes only 0x1d..0x21.
// - 16-bit signed active power offset added into active power.
// - 12-bit signed active power gain, 1/4096 per count, +-50 percent.
// - internal active energy divided by 8-bit divider before result.
// - 12-bit pulse rate numerator and denominator, both reset 0x3f.
// - current and voltage rms are separate 24-bit read-only registers.
// - 12-bit signed rms offsets; host writes only positive current one.
// - 12-bit signed apparent power gain, 1/4096 per count.
// - access opens with command byte: top bit write, low bits address.
// - data moves in bytes, msb first, right-justified; spare bits ignored.
`default_nettype none

package mcr_pkg;

  // ********************************
  // register addresses
  // ********************************
  localparam logic [5:0] ADDR_LINE_ENERGY = 6'h07;
  localparam logic [5:0] ADDR_OP_CTRL = 6'h09;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h0a;
  localparam logic [5:0] ADDR_FLAGS = 6'h0b;
  localparam logic [5:0] ADDR_FLAGS_CLR = 6'h0c;
  localparam logic [5:0] ADDR_CUR_OFFS = 6'h0d;
  localparam logic [5:0] ADDR_VOLT_OFFS = 6'h0e;
  localparam logic [5:0] ADDR_AMP_GAIN = 6'h0f;
  localparam logic [5:0] ADDR_PHASE_CAL = 6'h10;
  localparam logic [5:0] ADDR_ACT_OFFS = 6'h11;
  localparam logic [5:0] ADDR_ACT_GAIN = 6'h12;
  localparam logic [5:0] ADDR_ENERGY_DIV = 6'h13;
  localparam logic [5:0] ADDR_PULSE_NUM = 6'h14;
  localparam logic [5:0] ADDR_PULSE_DEN = 6'h15;
  localparam logic [5:0] ADDR_CUR_RMS = 6'h16;
  localparam logic [5:0] ADDR_VOLT_RMS = 6'h17;
  localparam logic [5:0] ADDR_CUR_RMS_OFFS = 6'h18;
  localparam logic [5:0] ADDR_VOLT_RMS_OFFS = 6'h19;
  localparam logic [5:0] ADDR_APP_GAIN = 6'h1a;

  // ********************************
  // reset values and field positions
  // ********************************
  localparam logic [15:0] RST_OP_CTRL = 16'h000c;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0040;
  localparam logic [5:0] RST_PHASE_CAL = 6'h0d;
  localparam logic [11:0] RST_PULSE_RATE = 12'h03f;
  localparam logic [7:0] CUR_OFFS_MASK = 8'hbf;
  localparam logic [7:0] VOLT_OFFS_MASK = 8'h3f;
  localparam int INTEG_BIT = 7;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam int GAIN_SHIFT = 12;
  localparam logic signed [13:0] GAIN_UNITY = 14'sh1000;

  typedef enum logic [1:0] {SER_CMD, SER_WRITE, SER_READ} mcr_ser_e;

  // results coming from the signal path
  typedef struct packed {
    logic [23:0] line_cycle_apparent_energy;
    logic [23:0] current_rms;
    logic [23:0] voltage_rms;
    logic signed [23:0] active_power_raw;
    logic signed [23:0] apparent_power_raw;
    logic [15:0] events;
  } mcr_meas_s;

  // settings handed to the signal path
  typedef struct packed {
    logic [15:0] operating_control;
    logic integrator_on;
    logic signed [5:0] current_offset;
    logic signed [5:0] voltage_offset;
    logic [7:0] programmable_gain_amp;
    logic signed [5:0] phase_calibration;
    logic signed [11:0] current_rms_offset;
    logic signed [11:0] voltage_rms_offset;
    logic [11:0] pulse_rate_numerator;
    logic [11:0] pulse_rate_denominator;
  } mcr_cfg_s;

  // software-visible storage
  typedef struct packed {
    logic [15:0] op_ctrl;
    logic [15:0] irq_mask;
    logic [15:0] flags;
    logic [7:0] cur_offs;
    logic [7:0] volt_offs;
    logic [7:0] amp_gain;
    logic [5:0] phase_cal;
    logic [15:0] act_offs;
    logic [11:0] act_gain;
    logic [7:0] energy_div;
    logic [11:0] pulse_num;
    logic [11:0] pulse_den;
    logic [11:0] cur_rms_offs;
    logic [11:0] volt_rms_offs;
    logic [11:0] app_gain;
  } mcr_regs_s;

endpackage : mcr_pkg

`default_nettype wire

// file: mcr_register_map.sv
`default_nettype none

module mcr_register_map #(
  parameter int ACC_W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial register port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // interrupt request, open drain, active low
  output logic irq_n_out,
  output logic irq_n_oe,
  // signal path
  input wire mcr_pkg::mcr_meas_s meas,
  input wire logic signed [ACC_W-1:0] active_energy_accum,
  output mcr_pkg::mcr_cfg_s cfg,
  output logic signed [23:0] active_power_cal,
  output logic signed [23:0] apparent_power_cal,
  output logic [23:0] active_energy_result
);
  import mcr_pkg::*;

  if (ACC_W < 24 || ACC_W > 48) begin : g_bad_width
    $error("ACC_W must lie between 24 and 48");
  end

  typedef struct packed {
    mcr_ser_e st;
    logic [4:0] cnt;
    logic [5:0] addr;
    logic [23:0] shreg;
    logic sclk_q;
    logic dout;
    logic dout_oe;
    logic irq_oe;
    mcr_regs_s regs;
    logic signed [23:0] act_pwr;
    logic signed [23:0] app_pwr;
    logic [23:0] energy;
  } mcr_state_s;

  mcr_state_s s;
  mcr_state_s next_s;

  // ********************************
  // helpers
  // ********************************
  // bytes moved for an address; unmapped addresses move one zero byte
  function automatic logic [1:0] reg_bytes(input logic [5:0] a);
    unique case (a)
      ADDR_LINE_ENERGY, ADDR_CUR_RMS, ADDR_VOLT_RMS: reg_bytes = 2'h3;
      ADDR_OP_CTRL, ADDR_IRQ_MASK, ADDR_FLAGS, ADDR_FLAGS_CLR,
      ADDR_ACT_OFFS, ADDR_ACT_GAIN, ADDR_PULSE_NUM, ADDR_PULSE_DEN,
      ADDR_CUR_RMS_OFFS, ADDR_VOLT_RMS_OFFS, ADDR_APP_GAIN: begin
        reg_bytes = 2'h2;
      end
      default: reg_bytes = 2'h1;
    endcase
  endfunction : reg_bytes

  function automatic logic [23:0] rd_value(input mcr_regs_s r,
                                           input mcr_meas_s m,
                                           input logic [5:0] a);
    unique case (a)
      ADDR_LINE_ENERGY: rd_value = m.line_cycle_apparent_energy;
      ADDR_OP_CTRL: rd_value = {8'h00, r.op_ctrl};
      ADDR_IRQ_MASK: rd_value = {8'h00, r.irq_mask};
      ADDR_FLAGS, ADDR_FLAGS_CLR: rd_value = {8'h00, r.flags};
      ADDR_CUR_OFFS: rd_value = {16'h0000, r.cur_offs};
      ADDR_VOLT_OFFS: rd_value = {16'h0000, r.volt_offs};
      ADDR_AMP_GAIN: rd_value = {16'h0000, r.amp_gain};
      ADDR_PHASE_CAL: rd_value = {18'h00000, r.phase_cal};
      ADDR_ACT_OFFS: rd_value = {8'h00, r.act_offs};
      ADDR_ACT_GAIN: rd_value = {12'h000, r.act_gain};
      ADDR_ENERGY_DIV: rd_value = {16'h0000, r.energy_div};
      ADDR_PULSE_NUM: rd_value = {12'h000, r.pulse_num};
      ADDR_PULSE_DEN: rd_value = {12'h000, r.pulse_den};
      ADDR_CUR_RMS: rd_value = m.current_rms;
      ADDR_VOLT_RMS: rd_value = m.voltage_rms;
      ADDR_CUR_RMS_OFFS: rd_value = {12'h000, r.cur_rms_offs};
      ADDR_VOLT_RMS_OFFS: rd_value = {12'h000, r.volt_rms_offs};
      ADDR_APP_GAIN: rd_value = {12'h000, r.app_gain};
      default: rd_value = 24'h000000;
    endcase
  endfunction : rd_value

  // one received byte lands in its lane; bits above the width drop
  function automatic mcr_regs_s wr_byte(input mcr_regs_s r,
                                        input logic [5:0] a,
                                        input logic [1:0] lane,
                                        input logic [7:0] b);
    logic [23:0] m;
    m = rd_value(r, '0, a);
    m[{lane, 3'b000} +: 8] = b;
    wr_byte = r;
    unique case (a)
      ADDR_OP_CTRL: wr_byte.op_ctrl = m[15:0];
      ADDR_IRQ_MASK: wr_byte.irq_mask = m[15:0];
      ADDR_CUR_OFFS: wr_byte.cur_offs = m[7:0] & CUR_OFFS_MASK;
      ADDR_VOLT_OFFS: wr_byte.volt_offs = m[7:0] & VOLT_OFFS_MASK;
      ADDR_AMP_GAIN: wr_byte.amp_gain = m[7:0];
      ADDR_PHASE_CAL: wr_byte.phase_cal = m[5:0];
      ADDR_ACT_OFFS: wr_byte.act_offs = m[15:0];
      ADDR_ACT_GAIN: wr_byte.act_gain = m[11:0];
      ADDR_ENERGY_DIV: wr_byte.energy_div = m[7:0];
      ADDR_PULSE_NUM: wr_byte.pulse_num = m[11:0];
      ADDR_PULSE_DEN: wr_byte.pulse_den = m[11:0];
      ADDR_CUR_RMS_OFFS: wr_byte.cur_rms_offs = m[11:0];
      ADDR_VOLT_RMS_OFFS: wr_byte.volt_rms_offs = m[11:0];
      ADDR_APP_GAIN: wr_byte.app_gain = m[11:0];
      default: wr_byte = r;
    endcase
  endfunction : wr_byte

  // six-bit sign-magnitude to twos complement
  function automatic logic signed [5:0] sm_to_signed(input logic [5:0] v);
    logic signed [5:0] mag;
    mag = $signed({1'b0, v[4:0]});
    sm_to_signed = v[5] ? -mag : mag;
  endfunction : sm_to_signed

  // scale by (4096 + g) / 4096; g spans +-2048, hence +-50 percent
  function automatic logic signed [23:0] scale_gain(
      input logic signed [23:0] p, input logic [11:0] g);
    logic signed [13:0] k;
    logic signed [37:0] prod;
    k = GAIN_UNITY + 14'($signed(g));
    prod = 38'(p) * 38'(k);
    scale_gain = 24'(prod >>> GAIN_SHIFT);
  endfunction : scale_gain

  // ********************************
  // next state
  // ********************************
  logic rise;
  logic fall;
  logic clr_flags;
  logic [7:0] rx_byte;
  logic [1:0] nbytes;
  logic [ACC_W-1:0] divisor;

  assign rise = sclk & ~s.sclk_q;
  assign fall = ~sclk & s.sclk_q;
  assign rx_byte = {s.shreg[6:0], din};
  assign nbytes = reg_bytes(s.addr);

  always_comb begin
    next_s = s;
    clr_flags = 1'b0;
    next_s.sclk_q = sclk;
    if (cs_n) begin
      // an unfinished byte is dropped; earlier bytes stay written
      next_s.st = SER_CMD;
      next_s.cnt = 5'h00;
      next_s.dout_oe = 1'b0;
    end else begin
      unique case (s.st)
        SER_CMD: begin
          if (fall) begin
            next_s.shreg = {s.shreg[22:0], din};
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == CMD_LAST_BIT) begin
              next_s.cnt = 5'h00;
              next_s.addr = rx_byte[5:0];
              if (rx_byte[CMD_WRITE_BIT]) begin
                next_s.st = SER_WRITE;
              end else begin
                // whole value captured now, so later updates cannot tear it
                next_s.st = SER_READ;
                next_s.shreg = rd_value(s.regs, meas, rx_byte[5:0])
                               << {2'h3 - reg_bytes(rx_byte[5:0]), 3'b000};
                clr_flags = (rx_byte[5:0] == ADDR_FLAGS_CLR);
              end
            end
          end
        end
        SER_WRITE: begin
          if (fall) begin
            next_s.shreg = {s.shreg[22:0], din};
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt[2:0] == 3'h7) begin
              next_s.regs = wr_byte(s.regs, s.addr,
                                    nbytes - 2'h1 - s.cnt[4:3], rx_byte);
              if (s.cnt[4:3] == nbytes - 2'h1) begin
                next_s.st = SER_CMD;
                next_s.cnt = 5'h00;
              end
            end
          end
        end
        SER_READ: begin
          if (rise) begin
            next_s.dout = s.shreg[23];
            next_s.dout_oe = 1'b1;
            next_s.shreg = {s.shreg[22:0], 1'b0};
            next_s.cnt = s.cnt + 5'h01;
          end else if (fall && s.cnt == {nbytes, 3'b000}) begin
            next_s.dout_oe = 1'b0;
            next_s.st = SER_CMD;
            next_s.cnt = 5'h00;
          end
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_s.regs.flags = (clr_flags ? 16'h0000 : next_s.regs.flags)
                        | meas.events;
    next_s.irq_oe = |(next_s.regs.flags & next_s.regs.irq_mask);
    // calibrated power and energy
    next_s.act_pwr = scale_gain(meas.active_power_raw, s.regs.act_gain)
                     + 24'($signed(s.regs.act_offs));
    next_s.app_pwr = scale_gain(meas.apparent_power_raw,
                                s.regs.app_gain);
    next_s.energy = 24'(active_energy_accum / $signed(divisor));
  end

  // divide by zero is treated as divide by one
  assign divisor = (s.regs.energy_div == 8'h00) ?
                   ACC_W'(1) : ACC_W'(s.regs.energy_div);

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= SER_CMD;
      // idle sclk is high; a low start would fake a rise at release
      s.sclk_q <= 1'b1;
      s.regs.op_ctrl <= RST_OP_CTRL;
      s.regs.irq_mask <= RST_IRQ_MASK;
      s.regs.phase_cal <= RST_PHASE_CAL;
      s.regs.pulse_num <= RST_PULSE_RATE;
      s.regs.pulse_den <= RST_PULSE_RATE;
    end else begin
      s <= next_s;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign dout = s.dout;
  assign dout_oe = s.dout_oe;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = s.irq_oe;
  assign active_power_cal = s.act_pwr;
  assign apparent_power_cal = s.app_pwr;
  assign active_energy_result = s.energy;

  always_comb begin
    cfg.operating_control = s.regs.op_ctrl;
    cfg.integrator_on = s.regs.cur_offs[INTEG_BIT];
    cfg.current_offset = sm_to_signed(s.regs.cur_offs[5:0]);
    // inverted: a negative code gives a positive offset
    cfg.voltage_offset = -sm_to_signed(s.regs.volt_offs[5:0]);
    cfg.programmable_gain_amp = s.regs.amp_gain;
    cfg.phase_calibration = $signed(s.regs.phase_cal);
    cfg.current_rms_offset = $signed(s.regs.cur_rms_offs);
    cfg.voltage_rms_offset = $signed(s.regs.volt_rms_offs);
    cfg.pulse_rate_numerator = s.regs.pulse_num;
    cfg.pulse_rate_denominator = s.regs.pulse_den;
  end

endmodule : mcr_register_map

`default_nettype wire

// file: mcr_register_map_checker.sv
`default_nettype none

module mcr_register_map_checker
  import mcr_pkg::*;
#(
  parameter int ACC_W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // interrupt pin
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  // signal path
  input wire mcr_pkg::mcr_meas_s meas,
  input wire logic signed [ACC_W-1:0] active_energy_accum,
  input wire mcr_pkg::mcr_cfg_s cfg,
  input wire logic signed [23:0] active_power_cal,
  input wire logic signed [23:0] apparent_power_cal,
  input wire logic [23:0] active_energy_result
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ********************************
  // assertions
  // ********************************
  a_irq_drive_low: assert property (irq_n_oe |-> !irq_n_out)
    else $error("irq line driven high");
  // mask writes may also raise the pin while a flag stands
  a_irq_has_cause: assert property ($rose(irq_n_oe) |->
    $past(|meas.events, 1) || $past(|meas.events, 2) || $past(!cs_n, 2))
    else $error("irq rose without event");
  a_reset_ctrl: assert property ($fell(rst) |->
    cfg.operating_control == RST_OP_CTRL &&
    cfg.phase_calibration == RST_PHASE_CAL &&
    cfg.pulse_rate_denominator == RST_PULSE_RATE)
    else $error("control reset value wrong");
  a_reset_integ: assert property ($fell(rst) |->
    !cfg.integrator_on && cfg.programmable_gain_amp == 8'h00 &&
    cfg.pulse_rate_numerator == RST_PULSE_RATE)
    else $error("gain or integrator reset wrong");
  a_oe_desel_off: assert property (cs_n ##1 cs_n |=> !dout_oe)
    else $error("dout driven while deselected");
  a_oe_needs_sel: assert property ($rose(dout_oe) |-> !$past(cs_n))
    else $error("dout enabled without select");
  a_dout_on_rise: assert property (
    $changed(dout) && dout_oe && $past(dout_oe) |-> $past(sclk))
    else $error("dout moved away from rising sclk");
  a_cfg_quiet: assert property ($changed(cfg) |-> !$past(cs_n))
    else $error("settings changed without access");
endmodule : mcr_register_map_checker

bind mcr_register_map mcr_register_map_checker #(.ACC_W(ACC_W)) u_chk (
  .clk_sys, .rst, .cs_n, .sclk, .din, .dout, .dout_oe, .irq_n_out,
  .irq_n_oe, .meas, .active_energy_accum, .cfg, .active_power_cal,
  .apparent_power_cal, .active_energy_result);

`default_nettype wire

// file: mcr_host_model.sv
`default_nettype none

module mcr_host_model (
  // clock
  input wire logic clk_sys,
  // serial lines
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  // read result, one-step pulse
  output logic [23:0] rd_data,
  output logic rd_done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    rd_data = 24'h0;
    rd_done = 1'b0;
  end

  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  // sclk high 3 cycles, low 2: dout settles before it is taken
  task bit_x(input logic b, output logic r);
    din = b;
    tick;
    tick;
    tick;
    r = dout;
    sclk = 1'b0;
    tick;
    tick;
    sclk = 1'b1;
  endtask : bit_x

  task xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd);
    logic r;
    logic [23:0] acc;
    acc = 24'h0;
    cs_n = 1'b0;
    tick;
    for (int i = 7; i >= 0; i--) begin
      bit_x(cmd[i], r);
    end
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      bit_x(wd[i], r);
      acc = {acc[22:0], r};
    end
    tick;
    tick;
    cs_n = 1'b1;
    // idle din never keeps the last bit
    din = ~din;
    rd_data = acc;
    rd_done = !cmd[7];
    tick;
    rd_done = 1'b0;
    tick;
  endtask : xfer

  // select, shift n bits msb first, then deselect mid-transfer
  task cut(input logic [15:0] bits, input int n);
    logic r;
    cs_n = 1'b0;
    tick;
    for (int i = 15; i > 15 - n; i--) begin
      bit_x(bits[i], r);
    end
    tick;
    cs_n = 1'b1;
    tick;
    tick;
  endtask : cut
endmodule : mcr_host_model

`default_nettype wire

// file: mcr_register_map_bench.sv
`default_nettype none

module mcr_register_map_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mcr_pkg::*;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe, irq_n_out, irq_n_oe, rd_done;
  logic dout_pin;
  mcr_meas_s meas = '0;
  logic signed [31:0] accum = '0;
  mcr_cfg_s cfg;
  logic signed [23:0] apc, vapc;
  logic [23:0] aer, rd_data;
  logic [23:0] mdl [64];
  logic [23:0] exp_q [$];
  logic [31:0] seed = 32'h46;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  always #25 clk_sys = ~clk_sys;

  // a released line shows the inverse, so a missing enable is caught
  assign dout_pin = dout_oe ? dout : ~dout;

  mcr_register_map #(.ACC_W(32)) u_mcr_register_map (.clk_sys, .rst,
    .cs_n, .sclk, .din, .dout, .dout_oe, .irq_n_out, .irq_n_oe, .meas,
    .active_energy_accum(accum), .cfg, .active_power_cal(apc),
    .apparent_power_cal(vapc), .active_energy_result(aer));
  mcr_host_model u_mcr_host_model (.clk_sys, .cs_n, .sclk, .din,
    .dout(dout_pin), .rd_data, .rd_done);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [23:0] wm(logic [5:0] a);
    case (a)
      6'h07, 6'h16, 6'h17: return 24'hffffff;
      6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h11: return 24'h00ffff;
      6'h0d: return 24'h0000bf;
      6'h0e, 6'h10: return 24'h00003f;
      6'h0f, 6'h13: return 24'h0000ff;
      6'h12, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1a: return 24'h000fff;
      default: return 24'h0;
    endcase
  endfunction : wm

  function automatic int nb(logic [5:0] a);
    return wm(a) > 24'h00ffff ? 3 : (wm(a) > 24'h0000ff ? 2 : 1);
  endfunction : nb

  task chk(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [23:0] v);
    u_mcr_host_model.xfer({2'b10, a}, nb(a), v);
    if (!(a inside {6'h07, 6'h0b, 6'h0c, 6'h16, 6'h17}))
      mdl[a] = v & wm(a);
  endtask : wr

  task rd(input logic [5:0] a);
    exp_q.push_back(mdl[a]);
    u_mcr_host_model.xfer({2'b00, a}, nb(a), 24'h0);
  endtask : rd

  task pulse(input logic [15:0] e);
    meas.events = e;
    u_mcr_host_model.tick;
    meas.events = 16'h0;
    repeat (3) u_mcr_host_model.tick;
  endtask : pulse

  task complete_run;
    chk(24'(exp_q.size()), 24'h0);
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge rd_done) begin
    chk(rd_data, exp_q.pop_front());
  end

  // about 10k cycles of traffic expected
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      $display("ERROR at %0t: timeout", $time);
      mismatches++;
      complete_run;
    end
  end

  initial begin
    logic [23:0] v, g;
    longint pr;
    int d;
    for (int i = 0; i < 64; i++) mdl[i] = 24'h0;
    mdl[9] = 24'(RST_OP_CTRL);
    mdl[10] = 24'(RST_IRQ_MASK);
    mdl[16] = 24'(RST_PHASE_CAL);
    mdl[20] = 24'(RST_PULSE_RATE);
    mdl[21] = 24'(RST_PULSE_RATE);
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    meas.line_cycle_apparent_energy = 24'(xs());
    meas.current_rms = 24'(xs());
    meas.voltage_rms = 24'(xs());
    mdl[7] = meas.line_cycle_apparent_energy;
    mdl[22] = meas.current_rms;
    mdl[23] = meas.voltage_rms;
    u_mcr_host_model.tick;
    for (int a = 7; a <= 26; a++) rd(6'(a));
    $display("test reset values done");
    for (int a = 7; a <= 26; a++) begin
      v = 24'(xs());
      if (a == 16) v = 24'h1d + v % 5;
      if (a == 24) v &= 24'h0007ff;
      wr(6'(a), v);
      rd(6'(a));
    end
    chk(cfg.operating_control, mdl[9]);
    chk(cfg.programmable_gain_amp, mdl[15]);
    chk({18'h0, cfg.phase_calibration}, mdl[16]);
    chk(cfg.pulse_rate_numerator, mdl[20]);
    chk(cfg.pulse_rate_denominator, mdl[21]);
    chk({12'h0, cfg.current_rms_offset}, mdl[24]);
    chk({12'h0, cfg.voltage_rms_offset}, mdl[25]);
    $display("test write readback done");
    wr(6'h0d, 24'h0000e5);
    chk(cfg.integrator_on, 1'b1);
    chk({18'h0, cfg.current_offset}, 24'h00003b);
    wr(6'h0e, 24'h0000e3);
    chk({18'h0, cfg.voltage_offset}, 24'h000003);
    rd(6'h0d);
    rd(6'h0e);
    wr(6'h0d, 24'h0);
    chk(cfg.integrator_on, 1'b0);
    $display("test offsets done");
    wr(6'h0a, 24'h000040);
    pulse(16'h0041);
    chk(irq_n_oe, 1'b1);
    mdl[11] = 24'h41;
    mdl[12] = 24'h41;
    rd(6'h0b);
    rd(6'h0c);
    mdl[11] = 24'h0;
    mdl[12] = 24'h0;
    rd(6'h0b);
    chk(irq_n_oe, 1'b0);
    pulse(16'h0001);
    chk(irq_n_oe, 1'b0);
    mdl[12] = 24'h1;
    rd(6'h0c);
    $display("test interrupts done");
    for (int i = 0; i < 3; i++) begin
      meas.active_power_raw = 24'(xs());
      meas.apparent_power_raw = 24'(xs());
      accum = 32'(xs() >> 1);
      g = 24'(xs());
      v = 24'(xs());
      d = i == 0 ? 0 : int'(xs() % 256);
      wr(6'h12, g);
      wr(6'h11, v);
      wr(6'h13, 24'(d));
      pr = longint'(meas.active_power_raw);
      chk(apc, 24'(((pr * (4096 + $signed(g[11:0]))) >>> 12)
        + $signed(v[15:0])));
      wr(6'h1a, v);
      pr = longint'(meas.apparent_power_raw);
      chk(vapc, 24'((pr * (4096 + $signed(v[11:0]))) >>> 12));
      chk(aer, 24'(accum / (d == 0 ? 1 : d)));
    end
    $display("test calibration done");
    // a byte cut short by deselect must not land
    u_mcr_host_model.cut({8'h8f, 8'h5a}, 12);
    rd(6'h0f);
    $display("test abort done");
    rst = 1'b1;
    repeat (2) u_mcr_host_model.tick;
    rst = 1'b0;
    mdl[9] = 24'(RST_OP_CTRL);
    mdl[10] = 24'(RST_IRQ_MASK);
    mdl[15] = 24'h0;
    mdl[16] = 24'(RST_PHASE_CAL);
    mdl[20] = 24'(RST_PULSE_RATE);
    mdl[26] = 24'h0;
    u_mcr_host_model.tick;
    rd(6'h09);
    rd(6'h0a);
    rd(6'h0f);
    rd(6'h10);
    rd(6'h14);
    rd(6'h1a);
    $display("test mid-run reset done");
    u_mcr_host_model.tick;
    complete_run;
  end
endmodule : mcr_register_map_bench

`default_nettype wire
